// File: hw/pbc_pkg.sv
// Shared constants for the port 1 transceiver basic control and status bank.
// Assumes a 16-bit register port with strobes and one-cycle read latency.
package pbc_pkg;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [3:0] ADDR_BASIC_CONTROL = 4'h0;
  localparam logic [3:0] ADDR_BASIC_STATUS  = 4'h2;
  localparam logic [3:0] ADDR_IRQ_STATUS    = 4'h4;
  localparam logic [3:0] ADDR_IRQ_MASK      = 4'h6;

  // ---------------------------------------------------------------
  // Control bit positions
  // ---------------------------------------------------------------
  localparam int CTL_FAR_LOOP   = 14;
  localparam int CTL_FORCE_100  = 13;
  localparam int CTL_AN_ENABLE  = 12;
  localparam int CTL_POWER_DOWN = 11;
  localparam int CTL_AN_RESTART = 9;
  localparam int CTL_FULL_DUP   = 8;
  localparam int CTL_XOVER_STD  = 5;
  localparam int CTL_FORCE_XOV  = 4;
  localparam int CTL_XOVER_OFF  = 3;
  localparam int CTL_SPARE      = 2;
  localparam int CTL_TX_OFF     = 1;
  localparam int CTL_LED_OFF    = 0;

  // Writable bits of the control register
  localparam logic [15:0] CTL_WRITE_MASK  = 16'h7b3f;
  localparam logic [15:0] CTL_RESET_VALUE = 16'h1020;

  // ---------------------------------------------------------------
  // Status bit positions
  // ---------------------------------------------------------------
  localparam int STS_AN_DONE = 5;
  localparam int STS_AN_ABLE = 3;
  localparam int STS_LINK_UP = 2;
  localparam int STS_EXT_CAP = 0;

  // Fixed capability bits: 100F, 100H, 10F, 10H set, T4 clear
  localparam logic [15:0] STS_FIXED_CAPS = 16'h7800;

  // ---------------------------------------------------------------
  // Interrupt event bits
  // ---------------------------------------------------------------
  localparam int IRQ_LINK_UP   = 0;
  localparam int IRQ_LINK_DOWN = 1;
  localparam int IRQ_AN_DONE   = 2;
  localparam int IRQ_EVENTS    = 3;

  localparam logic [15:0] REG_RESET_ZERO = 16'h0000;

endpackage : pbc_pkg

// File: hw/pbc_sync.sv
// Two-flop synchroniser for a bundle of level inputs.
// Assumes inputs are quasi-static levels from outside the clock domain.
`timescale 1ns/1ps
module pbc_sync #(
  parameter int WIDTH = 2
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] asyncIn,
  output logic      [WIDTH-1:0] syncOut
);
  logic [WIDTH-1:0] stage1_r;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      stage1_r <= '0;
      syncOut  <= '0;
    end else begin
      stage1_r <= asyncIn;
      syncOut  <= stage1_r;
    end
  end
endmodule : pbc_sync

// File: hw/pbc_irq.sv
// Sticky event status with write-one-to-clear, mask and one level interrupt.
// Assumes events are one-cycle pulses on the local clock.
`timescale 1ns/1ps
module pbc_irq
  import pbc_pkg::*;
(
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  input  wire logic [IRQ_EVENTS-1:0] eventPulse,
  input  wire logic                  clearWrite,
  input  wire logic                  maskWrite,
  input  wire logic [IRQ_EVENTS-1:0] wrData,
  output logic      [IRQ_EVENTS-1:0] status_r,
  output logic      [IRQ_EVENTS-1:0] mask_r,
  output logic                       irq_r
);
  // Set wins over a clear in the same cycle
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      status_r <= '0;
    end else begin
      status_r <= (status_r & ~(clearWrite ? wrData : '0)) | eventPulse;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mask_r <= '0;
    end else if (maskWrite) begin
      mask_r <= wrData;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irq_r <= 1'b0;
    end else begin
      // A set mask bit hides its event; reset mask leaves every event unmasked
      irq_r <= |(((status_r & ~(clearWrite ? wrData : '0)) | eventPulse) & ~mask_r);
    end
  end
endmodule : pbc_irq

// File: hw/pbc_port_ctrl.sv
// Port 1 transceiver basic control and status registers.
// Assumes a simple strobe register port on clk and transceiver status pins
// arriving asynchronously.
//
// How it works
// - Far-end loopback bit drives the port 1 loop enable for port 2 traffic.
// - With negotiation off, speed bit selects 100 Mbps set, 10 Mbps clear.
// - Negotiation enable resets to one; clearing it applies forced settings.
// - Writing one to restart bit pulses a negotiation restart.
// - Duplex bit forces full or half when negotiation off or failed.
// - Crossover style bit resets to one; selects standard or alternative algorithm.
// - Crossover disable and force bits steer crossover outputs.
// - Transmit disable and LED disable bits gate transmitter and indicators.
// - Capability bits read T4 zero and four speed/duplex bits one.
// - Negotiation complete reads finished state, resets to zero.
// - Negotiation ability bit always reads one.
// - Extended capability bit reads zero.
//
// Our own choice: the strobed register port.
`timescale 1ns/1ps
module pbc_port_ctrl
  import pbc_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [3:0]  regAddr,
  input  wire logic [15:0] regWrData,
  input  wire logic        regWrStb,
  input  wire logic        regRdStb,
  output logic      [15:0] regRdData,
  input  wire logic        phyLinkUp,
  input  wire logic        phyAnDone,
  input  wire logic        phyAnFailed,
  output logic             farEndLoop,
  output logic             anEnable,
  output logic             anRestart,
  output logic             speed100,
  output logic             fullDuplex,
  output logic             powerDown,
  output logic             xoverStandard,
  output logic             xoverAutoOff,
  output logic             xoverForce,
  output logic             txDisable,
  output logic             ledDisable,
  output logic             irq
);
  import pbc_pkg::*;

  // ---------------------------------------------------------------
  // Status inputs
  // ---------------------------------------------------------------
  logic [2:0] phySync;
  logic       linkUpS;
  logic       anDoneS;
  logic       anFailS;

  pbc_sync #(.WIDTH(3)) uSync (
    .clk     (clk),
    .rst_n   (rst_n),
    .asyncIn ({phyAnFailed, phyAnDone, phyLinkUp}),
    .syncOut (phySync)
  );

  assign linkUpS = phySync[0];
  assign anDoneS = phySync[1];
  assign anFailS = phySync[2];

  // ---------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------
  logic wrCtl;
  logic wrIrqSts;
  logic wrIrqMask;

  assign wrCtl     = regWrStb && (regAddr == ADDR_BASIC_CONTROL);
  assign wrIrqSts  = regWrStb && (regAddr == ADDR_IRQ_STATUS);
  assign wrIrqMask = regWrStb && (regAddr == ADDR_IRQ_MASK);

  // ---------------------------------------------------------------
  // Control register
  // ---------------------------------------------------------------
  logic [15:0] ctl_r;
  logic [15:0] ctl_nxt;

  always_comb begin
    ctl_nxt = ctl_r;
    if (wrCtl) begin
      ctl_nxt = regWrData & CTL_WRITE_MASK;
    end
    ctl_nxt[CTL_AN_RESTART] = 1'b0;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctl_r <= CTL_RESET_VALUE;
    end else begin
      ctl_r <= ctl_nxt;
    end
  end

  // Restart is self-clearing: one-cycle pulse out
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      anRestart <= 1'b0;
    end else begin
      anRestart <= wrCtl && regWrData[CTL_AN_RESTART];
    end
  end

  // ---------------------------------------------------------------
  // Control outputs
  // ---------------------------------------------------------------
  logic forcedMode;
  assign forcedMode = !ctl_nxt[CTL_AN_ENABLE] || anFailS;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      farEndLoop    <= CTL_RESET_VALUE[CTL_FAR_LOOP];
      anEnable      <= CTL_RESET_VALUE[CTL_AN_ENABLE];
      speed100      <= 1'b1;
      fullDuplex    <= 1'b1;
      powerDown     <= CTL_RESET_VALUE[CTL_POWER_DOWN];
      xoverStandard <= CTL_RESET_VALUE[CTL_XOVER_STD];
      xoverAutoOff  <= CTL_RESET_VALUE[CTL_XOVER_OFF];
      xoverForce    <= CTL_RESET_VALUE[CTL_FORCE_XOV];
      txDisable     <= CTL_RESET_VALUE[CTL_TX_OFF];
      ledDisable    <= CTL_RESET_VALUE[CTL_LED_OFF];
    end else begin
      farEndLoop    <= ctl_nxt[CTL_FAR_LOOP];
      anEnable      <= ctl_nxt[CTL_AN_ENABLE];
      // Negotiated result unknown here: advertise best when negotiating
      speed100      <= ctl_nxt[CTL_AN_ENABLE] ? 1'b1 : ctl_nxt[CTL_FORCE_100];
      fullDuplex    <= forcedMode ? ctl_nxt[CTL_FULL_DUP] : 1'b1;
      powerDown     <= ctl_nxt[CTL_POWER_DOWN];
      xoverStandard <= ctl_nxt[CTL_XOVER_STD];
      xoverAutoOff  <= ctl_nxt[CTL_XOVER_OFF];
      xoverForce    <= ctl_nxt[CTL_FORCE_XOV];
      txDisable     <= ctl_nxt[CTL_TX_OFF];
      ledDisable    <= ctl_nxt[CTL_LED_OFF];
    end
  end

  // ---------------------------------------------------------------
  // Status register
  // ---------------------------------------------------------------
  logic [15:0] sts;

  always_comb begin
    sts              = STS_FIXED_CAPS;
    sts[STS_AN_DONE] = anDoneS && ctl_r[CTL_AN_ENABLE] && !ctl_r[CTL_POWER_DOWN];
    sts[STS_AN_ABLE] = 1'b1;
    sts[STS_LINK_UP] = linkUpS && !ctl_r[CTL_POWER_DOWN];
    sts[STS_EXT_CAP] = 1'b0;
  end

  // ---------------------------------------------------------------
  // Events and interrupt
  // ---------------------------------------------------------------
  logic                  linkPrev_r;
  logic                  anPrev_r;
  logic [IRQ_EVENTS-1:0] events;
  logic [IRQ_EVENTS-1:0] irqStatus;
  logic [IRQ_EVENTS-1:0] irqMask;
  logic                  irqLevel;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      linkPrev_r <= 1'b0;
      anPrev_r   <= 1'b0;
    end else begin
      linkPrev_r <= sts[STS_LINK_UP];
      anPrev_r   <= sts[STS_AN_DONE];
    end
  end

  assign events[IRQ_LINK_UP]   = sts[STS_LINK_UP] && !linkPrev_r;
  assign events[IRQ_LINK_DOWN] = !sts[STS_LINK_UP] && linkPrev_r;
  assign events[IRQ_AN_DONE]   = sts[STS_AN_DONE] && !anPrev_r;

  pbc_irq uIrq (
    .clk        (clk),
    .rst_n      (rst_n),
    .eventPulse (events),
    .clearWrite (wrIrqSts),
    .maskWrite  (wrIrqMask),
    .wrData     (regWrData[IRQ_EVENTS-1:0]),
    .status_r   (irqStatus),
    .mask_r     (irqMask),
    .irq_r      (irqLevel)
  );

  assign irq = irqLevel;

  // ---------------------------------------------------------------
  // Read port
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      regRdData <= REG_RESET_ZERO;
    end else if (regRdStb) begin
      unique case (regAddr)
        ADDR_BASIC_CONTROL: regRdData <= ctl_r;
        ADDR_BASIC_STATUS:  regRdData <= sts;
        ADDR_IRQ_STATUS:    regRdData <= {{(16-IRQ_EVENTS){1'b0}}, irqStatus};
        ADDR_IRQ_MASK:      regRdData <= {{(16-IRQ_EVENTS){1'b0}}, irqMask};
        default:            regRdData <= REG_RESET_ZERO;
      endcase
    end else begin
      regRdData <= REG_RESET_ZERO;
    end
  end

endmodule : pbc_port_ctrl

// File: verification/pbc_port_ctrl_sva.sv
// Checker for the port 1 transceiver basic control and status bank.
// Assumes it is bound to pbc_port_ctrl and sees only its ports.
`timescale 1ns/1ps
module pbc_port_ctrl_chk
  import pbc_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic [3:0]  regAddr,
  input wire logic [15:0] regWrData,
  input wire logic        regWrStb,
  input wire logic        regRdStb,
  input wire logic [15:0] regRdData,
  input wire logic        farEndLoop,
  input wire logic        anEnable,
  input wire logic        anRestart,
  input wire logic        speed100,
  input wire logic        fullDuplex,
  input wire logic        powerDown,
  input wire logic        xoverStandard,
  input wire logic        xoverAutoOff,
  input wire logic        xoverForce,
  input wire logic        txDisable,
  input wire logic        ledDisable,
  input wire logic        irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ------------------------------
  // Sequences
  // ------------------------------
  sequence ctlWr;
    regWrStb && regAddr == ADDR_BASIC_CONTROL;
  endsequence
  sequence rstWr;
    ctlWr ##0 regWrData[9];
  endsequence
  sequence stsRd;
    $past(regRdStb) && $past(regAddr) == ADDR_BASIC_STATUS;
  endsequence
  // ------------------------------
  // Assertions
  // ------------------------------
  caps_fixed_a: assert property (stsRd |-> (regRdData & 16'hffdb) == 16'h7808)
    else $error("fixed status bits wrong");
  loop_pd_a: assert property (ctlWr |=> farEndLoop == $past(regWrData[14])
    && powerDown == $past(regWrData[11])) else $error("loop or power-down wrong");
  speed_sel_a: assert property (ctlWr |=> speed100 == ($past(regWrData[12]) |
    $past(regWrData[13]))) else $error("speed select wrong");
  an_enable_a: assert property (ctlWr |=> anEnable == $past(regWrData[12]))
    else $error("negotiation enable wrong");
  restart_pulse_a: assert property (rstWr |=> anRestart ##1 !anRestart)
    else $error("restart pulse wrong");
  duplex_force_a: assert property (ctlWr ##0 !regWrData[12] |=>
    fullDuplex == $past(regWrData[8])) else $error("forced duplex wrong");
  xover_sel_a: assert property (ctlWr |=> {xoverStandard, xoverForce, xoverAutoOff}
    == $past(regWrData[5:3])) else $error("crossover control wrong");
  tx_led_a: assert property (ctlWr |=> {txDisable, ledDisable} == $past(regWrData[1:0]))
    else $error("transmit or indicator control wrong");
  reset_vals_a: assert property ($rose(rst_n) |-> {anEnable, xoverStandard, speed100,
    fullDuplex, farEndLoop, powerDown, txDisable, ledDisable, irq} == 9'h1e0)
    else $error("reset values wrong");
endmodule : pbc_port_ctrl_chk

bind pbc_port_ctrl pbc_port_ctrl_chk chk_u (.*);

// File: verification/pbc_port_ctrl_bench.sv
// Self-checking bench for the port 1 basic control and status bank.
// Assumes the design package and checker are compiled first.
`timescale 1ns/1ps
module pbc_port_ctrl_bench;
  import pbc_pkg::*;
  logic        clk, rst_n, regWrStb, regRdStb, phyLinkUp, phyAnDone, phyAnFailed, rdPend;
  logic [3:0]  regAddr;
  logic [15:0] regWrData, regRdData, d;
  logic        farEndLoop, anEnable, anRestart, speed100, fullDuplex, powerDown;
  logic        xoverStandard, xoverAutoOff, xoverForce, txDisable, ledDisable, irq;
  logic [15:0] outs;
  logic [15:0] expQ[$];
  logic [31:0] rnd;
  int          errors, n_tests, cyc;

  pbc_port_ctrl dut_u (.*);
  assign outs = {4'h0, farEndLoop, anEnable, powerDown, speed100, fullDuplex,
                 xoverStandard, xoverForce, xoverAutoOff, txDisable, ledDisable, irq, 1'b0};

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // ------------------------------
  // Helpers
  // ------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    lfsr = {1'b0, x[31:1]} ^ (x[0] ? 32'h8020_0003 : 32'h0000_0000);
  endfunction : lfsr
  function automatic logic [15:0] expOuts(input logic [15:0] v);
    expOuts = {4'h0, v[14], v[12], v[11], v[12] | v[13], v[12] | v[8],
               v[5], v[4], v[3], v[1], v[0], 2'b00};
  endfunction : expOuts
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_tests++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    regAddr <= a;
    regWrData <= v;
    regWrStb <= 1'b1;
    @(posedge clk);
    regWrStb <= 1'b0;
    @(posedge clk);
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    regAddr <= a;
    regRdStb <= 1'b1;
    expQ.push_back(e);
    @(posedge clk);
    regRdStb <= 1'b0;
    @(posedge clk);
  endtask : rd
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
  endtask : settle
  task automatic summarize();
    $display("checks %0d errors %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : summarize
  // ------------------------------
  // Read monitor and timeout
  // ------------------------------
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (rdPend) chk("regRdData", expQ.pop_front(), regRdData);
    rdPend <= regRdStb;
    if (cyc == 2000) begin
      errors++;
      summarize();
    end
  end
  // ------------------------------
  // Main sequence
  // ------------------------------
  initial begin
    rst_n = 1'b0; regWrStb = 1'b0; regRdStb = 1'b0; regAddr = 4'h0; regWrData = 16'h0000;
    phyLinkUp = 1'b0; phyAnDone = 1'b0; phyAnFailed = 1'b0; rdPend = 1'b0;
    rnd = 32'hdf80; errors = 0; n_tests = 0; cyc = 0;
    settle(8);
    rst_n <= 1'b1;
    @(posedge clk);
    chk("outputs", expOuts(16'h1020), outs);
    rd(ADDR_BASIC_CONTROL, 16'h1020);
    rd(ADDR_BASIC_STATUS, 16'h7808);
    for (int i = 0; i < 12; i++) begin
      rnd = lfsr(rnd);
      d = {rnd[15:13], i[0], rnd[11:0]};
      wr(ADDR_BASIC_CONTROL, d);
      chk("outputs", expOuts(d), outs);
      rd(ADDR_BASIC_CONTROL, d & 16'h793f);
    end
    wr(ADDR_BASIC_STATUS, 16'hffff);
    wr(4'h8, 16'hffff);
    rd(4'h8, 16'h0000);
    wr(ADDR_BASIC_CONTROL, 16'h1000);
    rd(ADDR_BASIC_STATUS, 16'h7808);
    phyLinkUp <= 1'b1;
    phyAnDone <= 1'b1;
    settle(4);
    rd(ADDR_BASIC_STATUS, 16'h782c);
    chk("irq", 16'h0002, outs & 16'h0002);
    rd(ADDR_IRQ_STATUS, 16'h0005);
    wr(ADDR_IRQ_STATUS, 16'h0007);
    settle(1);
    chk("irq", 16'h0000, outs & 16'h0002);
    rd(ADDR_IRQ_STATUS, 16'h0000);
    wr(ADDR_IRQ_MASK, 16'h0007);
    phyLinkUp <= 1'b0;
    settle(4);
    rd(ADDR_BASIC_STATUS, 16'h7828);
    rd(ADDR_IRQ_STATUS, 16'h0002);
    chk("irq", 16'h0000, outs & 16'h0002);
    wr(ADDR_IRQ_MASK, 16'h0000);
    settle(1);
    chk("irq", 16'h0002, outs & 16'h0002);
    wr(ADDR_BASIC_CONTROL, 16'h1800);
    phyLinkUp <= 1'b1;
    settle(4);
    rd(ADDR_BASIC_STATUS, 16'h7808);
    wr(ADDR_BASIC_CONTROL, 16'h1000);
    phyAnFailed <= 1'b1;
    settle(4);
    chk("fullDuplex", 16'h0000, {15'h0000, fullDuplex});
    summarize();
  end
endmodule : pbc_port_ctrl_bench
